/* hdl/dlf_led_sequencer.sv */
// Top-level diagnostic LED sequencer: main, code and reset/run indicators.
`timescale 1ns/1ps
module dlf_led_sequencer
    import dlf_pkg::*;
#(
    parameter int FLASH = FLASH_CYC,
    parameter int STARTUP = STARTUP_CYC,
    parameter int BLINK = BLINK_CYC,
    parameter int DGAP = DIGIT_GAP_CYC,
    parameter int RGAP = REPEAT_GAP_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire dlf_main_cond_t main_cond,
    input wire dlf_selftest_t selftest,
    input wire dlf_rr_mode_t rr_mode,
    output dlf_led_t main_led,
    output dlf_led_t code_led,
    output dlf_led_t rr_led
);
    logic [31:0] ftmr_q, ftmr_d;
    logic phase_q, phase_d;
    logic was_startup_q;
    logic [3:0] d1, d2;
    logic code_lit;
    dlf_led_t main_d;

    // Code table; the lowest-numbered failure wins when several are flagged.
    always_comb begin
        d1 = DIGIT_NONE;
        d2 = DIGIT_NONE;
        if (selftest.ram_fail) begin
            d1 = DIGIT_ONE; d2 = DIGIT_FOUR;
        end else if (selftest.rtc_fail) begin
            d1 = DIGIT_TWO; d2 = DIGIT_TWO;
        end else if (selftest.fpu_fail) begin
            d1 = DIGIT_TWO; d2 = DIGIT_THREE;
        end else if (selftest.flash_fail) begin
            d1 = DIGIT_TWO; d2 = DIGIT_FOUR;
        end else if (selftest.secondary_flash_bank_fail) begin
            d1 = DIGIT_TWO; d2 = DIGIT_FIVE;
        end else if (selftest.i2c_fail) begin
            d1 = DIGIT_TWO; d2 = DIGIT_SIX;
        end
    end

    dlf_code_blinker #(.BLINK(BLINK), .DGAP(DGAP), .RGAP(RGAP)) u_code (
        .mclk(mclk),
        .resetn(resetn),
        .digit1(d1),
        .digit2(d2),
        .lit(code_lit)
    );

    // One timer toggles the phase each half period, so on and off are equal.
    always_comb begin
        ftmr_d = ftmr_q + 32'h1;
        phase_d = phase_q;
        if (main_cond.startup != was_startup_q) begin
            ftmr_d = 32'h0;
            phase_d = 1'b0;
        end else if (ftmr_q >= 32'((main_cond.startup ? STARTUP : FLASH) - 1)) begin
            ftmr_d = 32'h0;
            phase_d = !phase_q;
        end
        main_d = '0;
        if (main_cond.startup) begin
            main_d.red = !phase_q;
            main_d.green = phase_q;
        end else if (main_cond.shutdown_fault) begin
            main_d.red = phase_q;
        end else if (main_cond.no_demand) begin
            main_d.red = phase_q;
            main_d.green = phase_q;
        end else if (main_cond.normal) begin
            main_d.green = phase_q;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ftmr_q <= 32'h0;
            phase_q <= 1'b0;
            was_startup_q <= 1'b0;
            main_led <= '0;
            code_led <= '0;
            rr_led <= '0;
        end else begin
            ftmr_q <= ftmr_d;
            phase_q <= phase_d;
            was_startup_q <= main_cond.startup;
            main_led <= main_d;
            code_led.red <= code_lit;
            code_led.green <= 1'b0;
            rr_led.red <= (rr_mode == DLF_RR_RESET);
            rr_led.green <= (rr_mode == DLF_RR_RUN);
        end
    end

    sequence fault_sel_s;
        !main_cond.startup && main_cond.shutdown_fault;
    endsequence
    fault_red_a: assert property (@(posedge mclk) disable iff (!resetn)
        fault_sel_s ##1 fault_sel_s |-> !main_led.green) else $error("green during fault");
    orange_pair_a: assert property (@(posedge mclk) disable iff (!resetn)
        main_led.red && !main_cond.startup && $past(!main_cond.startup) && $past(main_cond.no_demand)
        && $past(!main_cond.shutdown_fault) |-> main_led.green) else $error("orange not paired");
    normal_green_a: assert property (@(posedge mclk) disable iff (!resetn)
        $past(main_cond.normal && !main_cond.startup && !main_cond.shutdown_fault && !main_cond.no_demand)
        |-> !main_led.red) else $error("red during normal");
    startup_alt_a: assert property (@(posedge mclk) disable iff (!resetn)
        $past(main_cond.startup) |-> main_led.red != main_led.green) else $error("startup not alternating");
    code_red_a: assert property (@(posedge mclk) disable iff (!resetn)
        !code_led.green) else $error("code LED green");
    rr_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
        rr_mode == DLF_RR_RESET |=> rr_led.red && !rr_led.green) else $error("reset not red");
    rr_run_a: assert property (@(posedge mclk) disable iff (!resetn)
        rr_mode == DLF_RR_RUN |=> rr_led.green && !rr_led.red) else $error("run not green");
    rr_ramtest_a: assert property (@(posedge mclk) disable iff (!resetn)
        rr_mode == DLF_RR_RAMTEST |=> !rr_led.green && !rr_led.red) else $error("ram test not dark");
    phase_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(phase_q) && !main_cond.startup && $past(!main_cond.startup) |=> $stable(phase_q))
        else $error("phase toggled too soon");
endmodule

/* hdl/dlf_pkg.sv */
// Package of constants and types for the diagnostic LED flash-code sequencer.
// Functional notes
// - Internal shutdown fault: main LED flashes red, 500 ms on, 500 ms off.
// - Normal operation: main LED flashes green, 500 ms on, 500 ms off.
// - No demand source or test mode: main LED flashes orange at 500 ms.
// - Start-up: main LED alternates red and green every 60 ms, then normal pattern.
// - Every main LED flash pattern has equal intervals: lit and dark, or red and green at start-up.
// - Code LED blinks first digit, pauses two seconds, blinks second digit.
// - After second digit, code LED is dark 5 s then repeats while active.
// - Every code blink is red only.
// - Codes: 1-4 memory, 2-2 clock, 2-3 FPU, 2-4 flash, 2-5 bank, 2-6 bus.
// - Reset/run LED solid red while communication processor is held in reset.
// - Reset/run LED solid green when running or booting; dark while preparing memory (RAM test).
package dlf_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int FLASH_MS = 500;
    localparam int STARTUP_MS = 60;
    localparam int DIGIT_GAP_MS = 2000;
    localparam int REPEAT_GAP_MS = 5000;
    localparam int BLINK_MS = 250;
    localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
    localparam int STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;
    localparam int DIGIT_GAP_CYC = CLK_HZ / 1000 * DIGIT_GAP_MS;
    localparam int REPEAT_GAP_CYC = CLK_HZ / 1000 * REPEAT_GAP_MS;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

    localparam logic [3:0] DIGIT_ONE = 4'h1;
    localparam logic [3:0] DIGIT_TWO = 4'h2;
    localparam logic [3:0] DIGIT_THREE = 4'h3;
    localparam logic [3:0] DIGIT_FOUR = 4'h4;
    localparam logic [3:0] DIGIT_FIVE = 4'h5;
    localparam logic [3:0] DIGIT_SIX = 4'h6;
    localparam logic [3:0] DIGIT_NONE = 4'h0;

    typedef struct packed {
        logic startup;
        logic shutdown_fault;
        logic no_demand;
        logic normal;
    } dlf_main_cond_t;

    typedef struct packed {
        logic ram_fail;
        logic rtc_fail;
        logic fpu_fail;
        logic flash_fail;
        logic secondary_flash_bank_fail;
        logic i2c_fail;
    } dlf_selftest_t;

    typedef struct packed {
        logic red;
        logic green;
    } dlf_led_t;

    typedef enum logic [1:0] {
        DLF_RR_RUN = 2'b00,
        DLF_RR_RESET = 2'b01,
        DLF_RR_RAMTEST = 2'b10
    } dlf_rr_mode_t;

    typedef enum logic [2:0] {
        DLF_CS_IDLE = 3'b000,
        DLF_CS_D1_ON = 3'b001,
        DLF_CS_D1_OFF = 3'b010,
        DLF_CS_GAP = 3'b011,
        DLF_CS_D2_ON = 3'b100,
        DLF_CS_D2_OFF = 3'b101,
        DLF_CS_PAUSE = 3'b110
    } dlf_code_state_t;
endpackage

/* hdl/dlf_code_blinker.sv */
// Two-digit blink sequencer for the communication-board diagnostic LED.
`timescale 1ns/1ps
module dlf_code_blinker
    import dlf_pkg::*;
#(
    parameter int BLINK = BLINK_CYC,
    parameter int DGAP = DIGIT_GAP_CYC,
    parameter int RGAP = REPEAT_GAP_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] digit1,
    input wire logic [3:0] digit2,
    output logic lit
);
    dlf_code_state_t state_q, state_d;
    logic [31:0] tmr_q, tmr_d;
    logic [3:0] cnt_q, cnt_d;
    logic active;

    assign active = (digit1 != DIGIT_NONE) && (digit2 != DIGIT_NONE);

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q + 32'h1;
        cnt_d = cnt_q;
        unique case (state_q)
            DLF_CS_IDLE: begin
                tmr_d = 32'h0;
                cnt_d = 4'h1;
                if (active) begin
                    state_d = DLF_CS_D1_ON;
                end
            end
            DLF_CS_D1_ON: if (tmr_q == 32'(BLINK - 1)) begin
                state_d = DLF_CS_D1_OFF;
                tmr_d = 32'h0;
            end
            DLF_CS_D1_OFF: if (tmr_q == 32'(BLINK - 1)) begin
                tmr_d = 32'h0;
                if (cnt_q >= digit1) begin
                    state_d = DLF_CS_GAP;
                end else begin
                    state_d = DLF_CS_D1_ON;
                    cnt_d = cnt_q + 4'h1;
                end
            end
            DLF_CS_GAP: if (tmr_q == 32'(DGAP - 1)) begin
                state_d = DLF_CS_D2_ON;
                tmr_d = 32'h0;
                cnt_d = 4'h1;
            end
            DLF_CS_D2_ON: if (tmr_q == 32'(BLINK - 1)) begin
                state_d = DLF_CS_D2_OFF;
                tmr_d = 32'h0;
            end
            DLF_CS_D2_OFF: if (tmr_q == 32'(BLINK - 1)) begin
                tmr_d = 32'h0;
                if (cnt_q >= digit2) begin
                    state_d = DLF_CS_PAUSE;
                end else begin
                    state_d = DLF_CS_D2_ON;
                    cnt_d = cnt_q + 4'h1;
                end
            end
            DLF_CS_PAUSE: if (tmr_q == 32'(RGAP - 1)) begin
                state_d = DLF_CS_IDLE;
                tmr_d = 32'h0;
            end
            default: state_d = DLF_CS_IDLE;
        endcase
        // A code that clears mid-pattern stops at once so a stale code is never shown.
        if (!active) begin
            state_d = DLF_CS_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= DLF_CS_IDLE;
            tmr_q <= 32'h0;
            cnt_q <= 4'h0;
            lit <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            cnt_q <= cnt_d;
            lit <= (state_d == DLF_CS_D1_ON) || (state_d == DLF_CS_D2_ON);
        end
    end

    pause_dark_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_q == DLF_CS_PAUSE) |=> !lit) else $error("code LED lit during repeat pause");
    gap_dark_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_q == DLF_CS_GAP) |-> !lit) else $error("code LED lit during digit gap");
endmodule

/* test/dlf_led_viewer.sv */
// Operator view of one bicolour LED: colours seen and length of the last steady run.
`timescale 1ns/1ps
module dlf_led_viewer
    import dlf_pkg::*;
(
    input wire logic mclk,
    input wire dlf_led_t led,
    input wire logic clr,
    output logic [3:0] seen,
    output int last_len
);
    dlf_led_t prev_q = 2'h0;
    int run_q = 0;
    initial seen = 4'h0;
    initial last_len = 0;
    // The eye only notices colour changes, so a run is timed from one change to the next.
    always @(posedge mclk) begin
        if (led != prev_q) begin
            last_len <= run_q;
            run_q <= 1;
        end else begin
            run_q <= run_q + 1;
        end
        prev_q <= led;
        seen <= clr ? 4'h0 : (seen | (4'h1 << led));
    end
endmodule

/* test/dlf_tb.sv */
// Self-checking bench for the diagnostic LED sequencer.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("FAIL %0t got %0h exp %0h", $time, got, exp); end end
module tb
    import dlf_pkg::*;
    ;
    localparam int FL = 8;
    localparam int ST = 4;
    localparam int BL = 3;
    localparam int DG = 10;
    localparam int RG = 12;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic clr = 1'b0;
    dlf_main_cond_t main_cond = 4'h0;
    dlf_selftest_t selftest = 6'h00;
    dlf_rr_mode_t rr_mode = DLF_RR_RUN;
    dlf_led_t main_led;
    dlf_led_t code_led;
    dlf_led_t rr_led;
    logic [3:0] seen;
    int last_len;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;

    always #10 mclk = ~mclk;

    dlf_led_sequencer #(.FLASH(FL), .STARTUP(ST), .BLINK(BL), .DGAP(DG), .RGAP(RG)) dut (
        .mclk(mclk), .resetn(resetn), .main_cond(main_cond), .selftest(selftest),
        .rr_mode(rr_mode), .main_led(main_led), .code_led(code_led), .rr_led(rr_led));

    dlf_led_viewer eye (.mclk(mclk), .led(main_led), .clr(clr), .seen(seen), .last_len(last_len));

    task automatic final_report();
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hang counts as a failure; the whole sequence needs well under this many cycles.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic rr_check(input dlf_rr_mode_t m, input dlf_led_t e);
        rr_mode = m;
        repeat (2) @(negedge mclk);
        `CHK(rr_led, e)
    endtask

    // Settle on the new pattern first so the transition does not pollute the colour set.
    task automatic main_check(input dlf_main_cond_t c, input logic [3:0] mask, input int half);
        main_cond = c;
        repeat (half + 3) @(negedge mclk);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        repeat (4 * half) @(negedge mclk);
        `CHK(seen, mask)
        `CHK(last_len, half)
    endtask

    task automatic code_check(input dlf_selftest_t s, input int d1, input int d2);
        int run;
        int n;
        int k;
        int grp[$];
        int gap[$];
        logic prev;
        // The dark stretch before the first blink is taken as a gap, so its length is never judged as a blink.
        run = BL + 1;
        n = 0;
        prev = 1'b0;
        selftest = s;
        for (int i = 0; i < 600 && gap.size() < 4; i++) begin
            @(negedge mclk);
            `CHK(code_led.green, 1'b0)
            if (code_led.red !== prev) begin
                if (prev) begin
                    n++;
                    `CHK(run, BL)
                end else if (run > BL) begin
                    grp.push_back(n);
                    gap.push_back(run);
                    n = 0;
                end else begin
                    `CHK(run, BL)
                end
                run = 0;
            end
            prev = code_led.red;
            run++;
        end
        `CHK(gap.size(), 4)
        if (gap.size() == 4) begin
            k = (gap[1] < gap[2]) ? 1 : 2;
            `CHK(grp[k], d1)
            `CHK(grp[k + 1], d2)
            `CHK((gap[k] >= DG) && (gap[k + 1] >= RG) && (gap[k + 1] > gap[k]), 1'b1)
        end
        selftest = 6'h00;
        repeat (2) @(negedge mclk);
        repeat (20) begin
            @(negedge mclk);
            `CHK(code_led, 2'b00)
        end
    endtask

    initial begin
        repeat (3) @(negedge mclk);
        `CHK({main_led, code_led, rr_led}, 6'h00)
        resetn = 1'b1;
        @(negedge mclk);
        rr_check(DLF_RR_RESET, 2'b10);
        rr_check(DLF_RR_RAMTEST, 2'b00);
        rr_check(DLF_RR_RUN, 2'b01);
        main_check(4'hf, 4'h6, ST);
        main_check(4'h7, 4'h5, FL);
        main_check(4'h3, 4'h9, FL);
        main_check(4'h1, 4'h3, FL);
        code_check(6'h20, 1, 4);
        code_check(6'h10, 2, 2);
        code_check(6'h08, 2, 3);
        code_check(6'h04, 2, 4);
        code_check(6'h02, 2, 5);
        code_check(6'h01, 2, 6);
        selftest = 6'h20;
        repeat (10) @(negedge mclk);
        resetn = 1'b0;
        @(negedge mclk);
        `CHK({main_led, code_led, rr_led}, 6'h00)
        final_report();
    end
endmodule
